// *** rtl/ectc_core.sv ***
// Eight 8-bit timers in four pairs with shared prescaler and register port
`timescale 1ns/1ps
`default_nettype none

module ectc_core #(
	parameter int NUM_PAIRS = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire ectc_pkg::ectc_bus_req_t bus_req,
	output logic [7:0] rd_data_ff,
	// External clock pins
	input wire logic timer0_external_clock_pin,
	input wire logic timer4_external_clock_pin,
	// Timer events
	output logic [7:0] timer_interrupt_request_ff,
	output logic [7:0] match_detect_ff,
	output logic [3:0] pair_output_flipflop_ff,
	// Prescaler taps for other peripherals
	output logic [3:0] prescaler_tap_ff
);

	generate
		if (NUM_PAIRS != ectc_pkg::PAIRS)
		begin : g_bad_pairs
			$error("ectc_core serves exactly four timer pairs");
		end
	endgenerate

	function automatic logic wr_to(input ectc_pkg::ectc_bus_req_t r, input logic [7:0] a);
		return r.wr && (r.addr == a);
	endfunction

	function automatic logic low_ones(input logic [8:0] v, input int msb);
		logic r;
		r = 1'b1;
		for (int i = 0; i < ectc_pkg::PRE_W; i++)
			if (i <= msb)
				r = r & v[i];
		return r;
	endfunction

	logic [7:0] run_ff;
	logic prerun_ff;
	logic [3:0] dbuf_ff;
	logic [7:0] ffc_ff [2];
	ectc_pkg::ectc_mode_t mode_ff [ectc_pkg::PAIRS];
	logic [1:0] fc_div_ff;
	logic [8:0] pre_cnt_ff;
	logic pre_en;
	logic [3:0] tap;
	logic [1:0] ext_meta_ff;
	logic [1:0] ext_sync_ff;
	logic [1:0] ext_prev_ff;
	logic [1:0] ext_rise;
	logic [7:0] irq_v;
	logic [7:0] match_v;
	logic [3:0] pair_ff_v;

	// Control registers
	// run cleared
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			run_ff <= ectc_pkg::RUN_RST;
		else if (wr_to(bus_req, ectc_pkg::ADDR_RUN))
			run_ff <= bus_req.wdata;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			prerun_ff <= ectc_pkg::PRERUN_RST;
		else if (wr_to(bus_req, ectc_pkg::ADDR_WIDE_RUN))
			prerun_ff <= bus_req.wdata[ectc_pkg::PRERUN_BIT];
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			dbuf_ff <= ectc_pkg::DBUF_RST;
		else if (wr_to(bus_req, ectc_pkg::ADDR_DBUF))
			dbuf_ff <= bus_req.wdata[3:0];
	end

	// Command bits act once on the write and are not kept
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ffc_ff[0] <= ectc_pkg::FFC_RST;
			ffc_ff[1] <= ectc_pkg::FFC_RST;
		end
		else
		begin
			if (wr_to(bus_req, ectc_pkg::ADDR_FFC_LOW))
				ffc_ff[0] <= bus_req.wdata & ectc_pkg::FFC_KEEP_MASK;
			if (wr_to(bus_req, ectc_pkg::ADDR_FFC_HIGH))
				ffc_ff[1] <= bus_req.wdata & ectc_pkg::FFC_KEEP_MASK;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			for (int p = 0; p < ectc_pkg::PAIRS; p++)
				mode_ff[p] <= ectc_pkg::MODE_RST;
		end
		else
		begin
			for (int p = 0; p < ectc_pkg::PAIRS; p++)
				if (wr_to(bus_req, ectc_pkg::ADDR_MODE[p]))
					mode_ff[p] <= bus_req.wdata;
		end
	end

	// Read port; compare values are write-only
	// reads as zero
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			rd_data_ff <= 8'h00;
		else if (bus_req.rd)
		begin
			rd_data_ff <= 8'h00;
			if (bus_req.addr == ectc_pkg::ADDR_RUN)
				rd_data_ff <= run_ff;
			if (bus_req.addr == ectc_pkg::ADDR_WIDE_RUN)
				rd_data_ff <= {prerun_ff, 7'h00};
			if (bus_req.addr == ectc_pkg::ADDR_DBUF)
				rd_data_ff <= {4'h0, dbuf_ff};
			if (bus_req.addr == ectc_pkg::ADDR_FFC_LOW)
				rd_data_ff <= ffc_ff[0];
			if (bus_req.addr == ectc_pkg::ADDR_FFC_HIGH)
				rd_data_ff <= ffc_ff[1];
			if (bus_req.addr == ectc_pkg::ADDR_STATUS)
				rd_data_ff <= {4'h0, pair_ff_v};
			for (int p = 0; p < ectc_pkg::PAIRS; p++)
				if (bus_req.addr == ectc_pkg::ADDR_MODE[p])
					rd_data_ff <= mode_ff[p];
		end
	end

	// Prescaler input enable at a quarter of sys_clk
	// enable not clock
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			fc_div_ff <= 2'h0;
		else
			fc_div_ff <= fc_div_ff + 2'h1;
	end

	assign pre_en = (fc_div_ff == 2'(ectc_pkg::PRE_IN_DIV - 1));

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n || !prerun_ff)
			pre_cnt_ff <= 9'h000;
		else if (pre_en)
			pre_cnt_ff <= pre_cnt_ff + 9'h001;
	end

	assign tap[0] = prerun_ff && pre_en && low_ones(pre_cnt_ff, ectc_pkg::TAP_DIV8_MSB);
	assign tap[1] = prerun_ff && pre_en && low_ones(pre_cnt_ff, ectc_pkg::TAP_DIV32_MSB);
	assign tap[2] = prerun_ff && pre_en && low_ones(pre_cnt_ff, ectc_pkg::TAP_DIV128_MSB);
	assign tap[3] = prerun_ff && pre_en && low_ones(pre_cnt_ff, ectc_pkg::TAP_DIV2048_MSB);

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
			prescaler_tap_ff <= 4'h0;
		else
			prescaler_tap_ff <= tap;
	end

	// Pins are asynchronous: two flops, then edge detect on the second
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ext_meta_ff <= 2'h0;
			ext_sync_ff <= 2'h0;
			ext_prev_ff <= 2'h0;
		end
		else
		begin
			ext_meta_ff <= {timer4_external_clock_pin, timer0_external_clock_pin};
			ext_sync_ff <= ext_meta_ff;
			ext_prev_ff <= ext_sync_ff;
		end
	end

	assign ext_rise = ext_sync_ff & ~ext_prev_ff;

	genvar gp;
	generate
		for (gp = 0; gp < ectc_pkg::PAIRS; gp++)
		begin : g_pair
			localparam int E = 2 * gp;
			localparam int O = 2 * gp + 1;
			ectc_pkg::ectc_mode_t md;
			logic [7:0] cnt_e_ff;
			logic [7:0] cnt_o_ff;
			logic [7:0] cmp_e_ff;
			logic [7:0] cmp_o_ff;
			logic [7:0] buf_ff;
			logic [7:0] nxt_e;
			logic [7:0] nxt_o;
			logic [7:0] wide_o;
			logic [7:0] pwm_top;
			logic ext_tick;
			logic tick_e;
			logic tick_o;
			logic hit_e;
			logic hit_o;
			logic wide_hit;
			logic cyc_hit;
			logic pwm_wrap;
			logic toggle;
			logic out_ff;
			logic [3:0] ffc;

			assign md = mode_ff[gp];
			assign ffc = ffc_ff[gp / 2][(gp % 2) * ectc_pkg::FFC_NIBBLE +: ectc_pkg::FFC_NIBBLE];
			assign nxt_e = cnt_e_ff + 8'h01;
			assign nxt_o = cnt_o_ff + 8'h01;

			// only timers 0 and 4 have a pin
			if (gp == 0)
			begin : g_ext0
				assign ext_tick = ext_rise[0];
			end
			else if (gp == 2)
			begin : g_ext4
				assign ext_tick = ext_rise[1];
			end
			else
			begin : g_noext
				assign ext_tick = 1'b0;
			end

			always_comb
			begin
				tick_e = 1'b0;
				unique case (md.even_clk)
					ectc_pkg::EVEN_EXT: tick_e = ext_tick;
					ectc_pkg::EVEN_T1: tick_e = tap[0];
					ectc_pkg::EVEN_T4: tick_e = tap[1];
					ectc_pkg::EVEN_T16: tick_e = tap[2];
				endcase
				tick_e = tick_e && run_ff[E];
			end

			assign hit_e = tick_e && (nxt_e == cmp_e_ff);

			always_comb
			begin
				tick_o = 1'b0;
				unique case (md.odd_clk)
					ectc_pkg::ODD_MATCH: tick_o = hit_e;
					ectc_pkg::ODD_T1: tick_o = tap[0];
					ectc_pkg::ODD_T16: tick_o = tap[2];
					ectc_pkg::ODD_PRESCALER_TAP_DIV2048: tick_o = tap[3];
				endcase
				if (md.pmode == ectc_pkg::PM_INT16)
					tick_o = tick_e && (cnt_e_ff == 8'hff);
				if (md.pmode == ectc_pkg::PM_PPG)
					tick_o = 1'b0;
				tick_o = tick_o && run_ff[O];
			end

			assign hit_o = tick_o && (nxt_o == cmp_o_ff);
			assign wide_o = tick_o ? nxt_o : cnt_o_ff;
			// Both halves must meet in the same step, so the 16-bit value matches once
			// A stopped odd half must not complete the 16-bit match on its own
			assign wide_hit = (md.pmode == ectc_pkg::PM_INT16) && tick_e && run_ff[O]
				&& (nxt_e == cmp_e_ff) && (wide_o == cmp_o_ff);
			// PPG: even compare sets the duty, odd compare sets the cycle
			assign cyc_hit = (md.pmode == ectc_pkg::PM_PPG) && tick_e
				&& (nxt_e == cmp_o_ff);

			always_comb
			begin
				unique case (md.pwm_n)
					2'h0: pwm_top = ectc_pkg::PWM_TOP6;
					2'h1: pwm_top = ectc_pkg::PWM_TOP7;
					default: pwm_top = ectc_pkg::PWM_TOP8;
				endcase
			end

			assign pwm_wrap = (md.pmode == ectc_pkg::PM_PWM) && tick_e && (cnt_e_ff == pwm_top);

			always_ff @(posedge sys_clk)
			begin
				if (!reset_n || !run_ff[E])
					cnt_e_ff <= 8'h00;
				else
				begin
					unique case (md.pmode)
						ectc_pkg::PM_INT8: cnt_e_ff <= hit_e ? 8'h00 : (tick_e ? nxt_e : cnt_e_ff);
						ectc_pkg::PM_INT16: cnt_e_ff <= wide_hit ? 8'h00 : (tick_e ? nxt_e : cnt_e_ff);
						ectc_pkg::PM_PPG: cnt_e_ff <= cyc_hit ? 8'h00 : (tick_e ? nxt_e : cnt_e_ff);
						ectc_pkg::PM_PWM: cnt_e_ff <= pwm_wrap ? 8'h00 : (tick_e ? nxt_e : cnt_e_ff);
					endcase
				end
			end

			always_ff @(posedge sys_clk)
			begin
				if (!reset_n || !run_ff[O])
					cnt_o_ff <= 8'h00;
				else if (md.pmode == ectc_pkg::PM_INT16)
					cnt_o_ff <= wide_hit ? 8'h00 : wide_o;
				else if (hit_o)
					cnt_o_ff <= 8'h00;
				else if (tick_o)
					cnt_o_ff <= nxt_o;
			end

			// Compare values are left unreset; counters stay stopped until the run register is written
			// shared address write
			always_ff @(posedge sys_clk)
			begin
				if (wr_to(bus_req, ectc_pkg::ADDR_CMP[E]))
					buf_ff <= bus_req.wdata;
			end

			always_ff @(posedge sys_clk)
			begin
				if (wr_to(bus_req, ectc_pkg::ADDR_CMP[E]) && !dbuf_ff[gp])
					cmp_e_ff <= bus_req.wdata;
				else if (dbuf_ff[gp] && (cyc_hit || pwm_wrap))
					cmp_e_ff <= buf_ff;
			end

			always_ff @(posedge sys_clk)
			begin
				if (wr_to(bus_req, ectc_pkg::ADDR_CMP[O]))
					cmp_o_ff <= bus_req.wdata;
			end

			always_comb
			begin
				unique case (md.pmode)
					ectc_pkg::PM_INT8: irq_v[E] = hit_e;
					ectc_pkg::PM_PPG: irq_v[E] = cyc_hit;
					ectc_pkg::PM_PWM: irq_v[E] = pwm_wrap;
					default: irq_v[E] = 1'b0;
				endcase
				irq_v[O] = (md.pmode == ectc_pkg::PM_INT16) ? wide_hit : hit_o;
				match_v[E] = hit_e || cyc_hit;
				match_v[O] = (md.pmode == ectc_pkg::PM_INT16) ? wide_hit : hit_o;
			end

			always_comb
			begin
				unique case (md.pmode)
					ectc_pkg::PM_INT8: toggle = ffc[ectc_pkg::FFC_SRC_BIT] ? hit_o : hit_e;
					ectc_pkg::PM_INT16: toggle = wide_hit;
					ectc_pkg::PM_PPG: toggle = hit_e || cyc_hit;
					ectc_pkg::PM_PWM: toggle = hit_e || pwm_wrap;
				endcase
			end

			// one output flip-flop per pair; software command beats a match
			always_ff @(posedge sys_clk)
			begin
				if (!reset_n)
					out_ff <= 1'b0;
				else if (wr_to(bus_req, gp < 2 ? ectc_pkg::ADDR_FFC_LOW : ectc_pkg::ADDR_FFC_HIGH)
					&& (bus_req.wdata[(gp % 2) * ectc_pkg::FFC_NIBBLE +: 2] != 2'h3))
				begin
					unique case (bus_req.wdata[(gp % 2) * ectc_pkg::FFC_NIBBLE +: 2])
						ectc_pkg::FF_CLEAR: out_ff <= 1'b0;
						ectc_pkg::FF_SET: out_ff <= 1'b1;
						default: out_ff <= ~out_ff;
					endcase
				end
				else if (toggle && ffc[ectc_pkg::FFC_INV_BIT])
					out_ff <= ~out_ff;
			end

			assign pair_ff_v[gp] = out_ff;
		end
	endgenerate

	assign pair_output_flipflop_ff = pair_ff_v;

	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			timer_interrupt_request_ff <= 8'h00;
			match_detect_ff <= 8'h00;
		end
		else
		begin
			timer_interrupt_request_ff <= irq_v;
			match_detect_ff <= match_v;
		end
	end

endmodule

`default_nettype wire

// *** rtl/ectc_pkg.sv ***
// Shared constants and types for the eight-channel 8-bit timer core
package ectc_pkg;

	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;
	localparam int PAIRS = 4;
	localparam int TIMERS = 8;

	// Register map
	localparam logic [7:0] ADDR_RUN = 8'h20;
	localparam logic [7:0] ADDR_WIDE_RUN = 8'h21;
	localparam logic [7:0] ADDR_FFC_LOW = 8'h25;
	localparam logic [7:0] ADDR_FFC_HIGH = 8'h2c;
	localparam logic [7:0] ADDR_DBUF = 8'h30;
	localparam logic [7:0] ADDR_STATUS = 8'h31;
	localparam logic [7:0] ADDR_MODE [PAIRS] = '{8'h24, 8'h28, 8'h2b, 8'h2f};
	localparam logic [7:0] ADDR_CMP [TIMERS] =
		'{8'h22, 8'h23, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2d, 8'h2e};

	// Reset values
	localparam logic [7:0] RUN_RST = 8'h00;
	localparam logic PRERUN_RST = 1'b0;
	localparam logic [3:0] DBUF_RST = 4'h0;
	localparam logic [7:0] FFC_RST = 8'h00;
	localparam logic [7:0] MODE_RST = 8'h00;

	// Field positions
	localparam int PRERUN_BIT = 7;
	localparam int FFC_NIBBLE = 4;
	localparam int FFC_INV_BIT = 2;
	localparam int FFC_SRC_BIT = 3;
	localparam logic [7:0] FFC_KEEP_MASK = 8'hcc;

	// Prescaler: fed at the CPU clock divided by four, 9-bit divider
	localparam int PRE_IN_DIV = 4;
	localparam int PRE_W = 9;
	localparam int TAP_DIV8_MSB = 0;
	localparam int TAP_DIV32_MSB = 2;
	localparam int TAP_DIV128_MSB = 4;
	localparam int TAP_DIV2048_MSB = 8;

	// Flip-flop software commands
	localparam logic [1:0] FF_INVERT = 2'h0;
	localparam logic [1:0] FF_CLEAR = 2'h1;
	localparam logic [1:0] FF_SET = 2'h2;

	// PWM cycle tops (2^n - 1)
	localparam logic [7:0] PWM_TOP6 = 8'h3f;
	localparam logic [7:0] PWM_TOP7 = 8'h7f;
	localparam logic [7:0] PWM_TOP8 = 8'hff;

	typedef enum logic [1:0] {
		PM_INT8 = 2'h0,
		PM_INT16 = 2'h1,
		PM_PPG = 2'h2,
		PM_PWM = 2'h3
	} ectc_pmode_t;

	typedef enum logic [1:0] {
		EVEN_EXT = 2'h0,
		EVEN_T1 = 2'h1,
		EVEN_T4 = 2'h2,
		EVEN_T16 = 2'h3
	} ectc_even_clk_t;

	typedef enum logic [1:0] {
		ODD_MATCH = 2'h0,
		ODD_T1 = 2'h1,
		ODD_T16 = 2'h2,
		ODD_PRESCALER_TAP_DIV2048 = 2'h3
	} ectc_odd_clk_t;

	typedef struct packed {
		ectc_pmode_t pmode;
		logic [1:0] pwm_n;
		ectc_odd_clk_t odd_clk;
		ectc_even_clk_t even_clk;
	} ectc_mode_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ectc_bus_req_t;

endpackage

// *** test/ectc_props.sv ***
// Port-level checker for the timer core, bound into every instance
`timescale 1ns/1ps
`default_nettype none
module ectc_props #(
	parameter int NUM_PAIRS = 4
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register port
	input wire ectc_pkg::ectc_bus_req_t bus_req,
	input wire logic [7:0] rd_data_ff,
	// Events
	input wire logic [7:0] timer_interrupt_request_ff,
	input wire logic [7:0] match_detect_ff,
	input wire logic [3:0] prescaler_tap_ff
);
	logic [7:0] run_ff;
	logic pre_ff;
	logic [3:0] dbuf_ff;
	logic [7:0] evt;
	logic dark;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	assign evt = match_detect_ff | timer_interrupt_request_ff;
	assign dark = bus_req.addr inside {[8'h00:8'h1f], [8'h32:8'hff], 8'h22, 8'h23, 8'h26,
		8'h27, 8'h29, 8'h2a, 8'h2d, 8'h2e};
	// Shadow of the run, prescaler run and buffer enable registers, rebuilt from bus writes
	always_ff @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			run_ff <= ectc_pkg::RUN_RST;
			pre_ff <= ectc_pkg::PRERUN_RST;
			dbuf_ff <= ectc_pkg::DBUF_RST;
		end
		else if (bus_req.wr)
		begin
			if (bus_req.addr == ectc_pkg::ADDR_RUN)
				run_ff <= bus_req.wdata;
			if (bus_req.addr == ectc_pkg::ADDR_WIDE_RUN)
				pre_ff <= bus_req.wdata[ectc_pkg::PRERUN_BIT];
			if (bus_req.addr == ectc_pkg::ADDR_DBUF)
				dbuf_ff <= bus_req.wdata[3:0];
		end
	end
	dark_read_zero_a: assert property (bus_req.rd && dark |=> rd_data_ff == 8'h00)
		else $error("write-only or unmapped read not zero");
	run_readback_a: assert property (bus_req.rd && bus_req.addr == ectc_pkg::ADDR_RUN
		|=> rd_data_ff == $past(run_ff)) else $error("run control readback wrong");
	pre_readback_a: assert property (bus_req.rd && bus_req.addr == ectc_pkg::ADDR_WIDE_RUN
		|=> rd_data_ff == {$past(pre_ff), 7'h00}) else $error("prescaler readback wrong");
	dbuf_readback_a: assert property (bus_req.rd && bus_req.addr == ectc_pkg::ADDR_DBUF
		|=> rd_data_ff == {4'h0, $past(dbuf_ff)}) else $error("buffer enable readback wrong");
	rd_hold_a: assert property (!bus_req.rd |=> $stable(rd_data_ff))
		else $error("read data changed without a read");
	tap_halt_a: assert property (!pre_ff && !$past(pre_ff) |-> prescaler_tap_ff == 4'h0)
		else $error("tap while prescaler stopped");
	tap_gap_a: assert property (prescaler_tap_ff[0] |=> !prescaler_tap_ff[0] [*7])
		else $error("fastest tap closer than eight cycles");
	run_gate_a: assert property ((evt & ~run_ff & ~$past(run_ff)) == 8'h00)
		else $error("event from a stopped timer");
	irq_single_a: assert property ((timer_interrupt_request_ff
		& $past(timer_interrupt_request_ff)) == 8'h00) else $error("request longer than a cycle");
endmodule
bind ectc_core ectc_props #(.NUM_PAIRS(NUM_PAIRS)) u_props (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.bus_req(bus_req),
	.rd_data_ff(rd_data_ff),
	.timer_interrupt_request_ff(timer_interrupt_request_ff),
	.match_detect_ff(match_detect_ff),
	.prescaler_tap_ff(prescaler_tap_ff)
);
`default_nettype wire

// *** test/testbench.sv ***
// Self-checking bench for the eight-channel timer core
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct {
		int pair;
		logic [7:0] mode;
		logic [7:0] ce;
		logic [7:0] co;
		logic [7:0] run;
		int tmr;
		int per;
	} ectc_row_t;
	// Pair, mode, even and odd compare, run mask, timer watched, period in cycles
	ectc_row_t rows [9] = '{
		'{0, 8'h01, 8'h03, 8'h00, 8'h01, 0, 24},
		'{1, 8'h02, 8'h02, 8'h00, 8'h04, 2, 64},
		'{2, 8'h03, 8'h01, 8'h00, 8'h10, 4, 128},
		'{0, 8'h04, 8'h00, 8'h05, 8'h02, 1, 40},
		'{1, 8'h08, 8'h00, 8'h01, 8'h08, 3, 128},
		'{2, 8'h0c, 8'h00, 8'h01, 8'h20, 5, 2048},
		'{3, 8'h01, 8'h00, 8'h00, 8'h40, 6, 2048},
		'{3, 8'h01, 8'h01, 8'h02, 8'hc0, 7, 16},
		'{3, 8'h81, 8'h02, 8'h05, 8'h40, 6, 40}
	};
	logic [1:0] ffcmd [3] = '{2'h2, 2'h1, 2'h0};
	logic ffexp [3] = '{1'b1, 1'b0, 1'b1};
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	ectc_pkg::ectc_bus_req_t bus_req = '0;
	logic pin4 = 1'b0;
	logic pin0 = 1'b0;
	int m0;
	logic [7:0] rdata;
	logic [7:0] irq;
	logic [7:0] mdet;
	logic [3:0] pff;
	logic [3:0] tap;
	int err_total = 0;
	int comparisons = 0;
	int icnt [8] = '{default: 0};
	int taps = 0;
	int n;
	int m;

	ectc_core #(.NUM_PAIRS(4)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .bus_req(bus_req), .rd_data_ff(rdata),
		.timer0_external_clock_pin(pin0), .timer4_external_clock_pin(pin4),
		.timer_interrupt_request_ff(irq), .match_detect_ff(mdet),
		.pair_output_flipflop_ff(pff), .prescaler_tap_ff(tap)
	);

	always #2.5 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
	begin
		foreach (icnt[b])
			if (irq[b] === 1'b1)
				icnt[b] <= icnt[b] + 1;
		if (tap !== 4'h0)
			taps <= taps + 1;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		bus_req <= {1'b1, 1'b0, a, d};
		@(posedge sys_clk);
		bus_req.wr <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		bus_req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge sys_clk);
		bus_req.rd <= 1'b0;
		#1 chk($sformatf("read %h", a), {8'h00, e}, {8'h00, rdata});
	endtask

	// Cycles until the next request of timer i, bounded by lim
	task automatic wait_irq(input int i, input int lim, output int c);
		c = 0;
		do
		begin
			@(posedge sys_clk);
			#1 c++;
		end
		while (irq[i] !== 1'b1 && c < lim);
	endtask

	task automatic wait_chg(input int p, output int c);
		logic v;
		v = pff[p];
		c = 0;
		do
		begin
			@(posedge sys_clk);
			#1 c++;
		end
		while (pff[p] === v && c < 4000);
	endtask

	initial
	begin
		// About twice the longest expected run
		repeat (40000) @(posedge sys_clk);
		err_total++;
		final_report;
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		wr(ectc_pkg::ADDR_WIDE_RUN, 8'h80);
		rdc(ectc_pkg::ADDR_WIDE_RUN, 8'h80);
		foreach (rows[k])
		begin
			wr(ectc_pkg::ADDR_RUN, 8'h00);
			wr(ectc_pkg::ADDR_MODE[rows[k].pair], rows[k].mode);
			wr(ectc_pkg::ADDR_CMP[2 * rows[k].pair], rows[k].ce);
			wr(ectc_pkg::ADDR_CMP[2 * rows[k].pair + 1], rows[k].co);
			wr(ectc_pkg::ADDR_RUN, rows[k].run);
			wait_irq(rows[k].tmr, 5000, n);
			wait_irq(rows[k].tmr, 5000, n);
			chk("interval period", 16'(rows[k].per), 16'(n));
		end
		// Odd clock field set on purpose: wide mode must ignore it
		wr(ectc_pkg::ADDR_RUN, 8'h00);
		wr(ectc_pkg::ADDR_MODE[0], 8'h4d);
		wr(ectc_pkg::ADDR_CMP[0], 8'h02);
		wr(ectc_pkg::ADDR_CMP[1], 8'h01);
		wr(ectc_pkg::ADDR_RUN, 8'h03);
		m = icnt[0];
		wait_irq(1, 6000, n);
		wait_irq(1, 6000, n);
		chk("wide period", 16'd2064, 16'(n));
		chk("even request in wide mode", 16'd0, 16'(icnt[0] - m));
		wr(ectc_pkg::ADDR_RUN, 8'h00);
		wr(ectc_pkg::ADDR_MODE[1], 8'hc1);
		wr(ectc_pkg::ADDR_FFC_LOW, 8'h73);
		wr(ectc_pkg::ADDR_CMP[2], 8'h10);
		wr(ectc_pkg::ADDR_DBUF, 8'h02);
		rdc(ectc_pkg::ADDR_DBUF, 8'h02);
		wr(ectc_pkg::ADDR_RUN, 8'h04);
		wait_irq(2, 2000, n);
		// Keep clear of the wrap toggle before the buffered write
		repeat (20) @(posedge sys_clk);
		wr(ectc_pkg::ADDR_CMP[2], 8'h20);
		wait_chg(1, n);
		wait_chg(1, n);
		chk("pwm span before transfer", 16'd384, 16'(n));
		wait_chg(1, n);
		chk("pwm span after transfer", 16'd256, 16'(n));
		wr(ectc_pkg::ADDR_RUN, 8'h00);
		wr(ectc_pkg::ADDR_DBUF, 8'h00);
		foreach (ffcmd[j])
		begin
			wr(ectc_pkg::ADDR_FFC_LOW, {6'h0c, ffcmd[j]});
			#1 chk("pair flip-flop", {15'h0, ffexp[j]}, {15'h0, pff[0]});
		end
		wr(ectc_pkg::ADDR_MODE[0], 8'h00);
		wr(ectc_pkg::ADDR_CMP[0], 8'h03);
		wr(ectc_pkg::ADDR_MODE[2], 8'h00);
		wr(ectc_pkg::ADDR_CMP[4], 8'h03);
		wr(ectc_pkg::ADDR_RUN, 8'h11);
		m = icnt[4];
		m0 = icnt[0];
		repeat (2)
		begin
			repeat (10) @(posedge sys_clk);
			pin4 <= 1'b1;
			pin0 <= 1'b1;
			repeat (10) @(posedge sys_clk);
			pin4 <= 1'b0;
			pin0 <= 1'b0;
		end
		repeat (10) @(posedge sys_clk);
		chk("pin request too early", 16'd0, 16'(icnt[4] - m));
		chk("pin0 request too early", 16'd0, 16'(icnt[0] - m0));
		pin4 <= 1'b1;
		pin0 <= 1'b1;
		wait_irq(4, 20, n);
		chk("pin third edge", 16'd3, 16'(n));
		chk("pin match", 16'd1, {15'h0, mdet[4]});
		chk("pin0 match", 16'd1, {15'h0, mdet[0]});
		pin4 <= 1'b0;
		pin0 <= 1'b0;
		wr(ectc_pkg::ADDR_WIDE_RUN, 8'h00);
		rdc(ectc_pkg::ADDR_WIDE_RUN, 8'h00);
		m = taps;
		repeat (3000) @(posedge sys_clk);
		chk("taps while stopped", 16'd0, 16'(taps - m));
		wr(ectc_pkg::ADDR_WIDE_RUN, 8'h80);
		wr(ectc_pkg::ADDR_DBUF, 8'h02);
		wr(ectc_pkg::ADDR_RUN, 8'hff);
		reset_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdc(ectc_pkg::ADDR_RUN, 8'h00);
		rdc(ectc_pkg::ADDR_WIDE_RUN, 8'h00);
		rdc(ectc_pkg::ADDR_DBUF, 8'h00);
		for (int j = 0; j < 8; j++)
			rdc(ectc_pkg::ADDR_CMP[j], 8'h00);
		rdc(8'h40, 8'h00);
		final_report;
	end
endmodule
`default_nettype wire
